// *** src/hw_reset_pkg.sv ***
// Constants and types shared by the display hardware reset sequencer.
package hw_reset_pkg;
    localparam int CLK_MHZ = 125;
    // Qualifying time for both edges of the reset pin; it lies between the spike and the sure-reset bounds.
    localparam int SPIKE_TIME_NS = 5000;
    localparam int SURE_RESET_TIME_NS = 9000;
    localparam int QUAL_TIME_NS = 7000;
    localparam int QUAL_CYCLES = (QUAL_TIME_NS * CLK_MHZ) / 1000;
    localparam int QCNT_W = 10;
    // Blanking runs for less than its 120 ms ceiling.
    localparam int BLANK_MAX_MS = 120;
    localparam int BLANK_TIME_MS = 100;
    localparam int BLANK_CYCLES = BLANK_TIME_MS * CLK_MHZ * 1000;
    localparam int RELEASE_SLEEP_MS = 5;
    localparam int RELEASE_AWAKE_MS = 120;
    localparam int LOAD_LIMIT_CYCLES = 4000;
    localparam int TCNT_W = 24;
    localparam int SETTINGS_WORDS = 8;
    localparam int IDX_W = 3;
    localparam int ID0_INDEX = 0;
    localparam int ID1_INDEX = 1;
    localparam int ID2_INDEX = 2;
    localparam int TRIM_INDEX = 3;
    localparam logic [7:0] SETTING_RESET = 8'h00;
    localparam logic [IDX_W-1:0] LAST_INDEX = 3'h7;
    typedef enum logic [1:0] {
        ST_READY = 2'b00,
        ST_BLANK = 2'b01,
        ST_HOLD = 2'b10,
        ST_LOAD = 2'b11
    } seq_state_e;
endpackage : hw_reset_pkg

// *** src/display_hw_reset_sequencer.sv ***
// Hardware reset sequencer: pin filter, blanking, settings load and command gating.
// Summary of operation
// - Low pulses under 5 us are rejected; pulses over 9 us always reset.
// - Short high glitches during a held reset neither end nor restart it.
// - On release, identification bytes, voltage trim and settings load from the store.
// - Settings load starts on every release, within 5 ms of the rising edge, except a release during blanking, where it starts when blanking ends.
// - Reset applied in sleep completes and becomes ready within 5 ms.
// - Reset applied while awake completes within 120 ms.
// - Reset starting from ready while awake runs a blanking sequence of at most 120 ms.
// - Reset in sleep keeps the display blank, with no blanking sequence.
// - During reset every setting word returns to its hardware default, then the settings reload from the store on release.
`timescale 1ns/1ps
module display_hw_reset_sequencer #(
    parameter logic [hw_reset_pkg::TCNT_W-1:0] BLANK_CYCLES = hw_reset_pkg::TCNT_W'(hw_reset_pkg::BLANK_CYCLES)
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic hwResetN,
    input wire logic displayAwake,
    output logic blankDisplay,
    output logic coreResetN,
    output logic cmdReady,
    output logic storeReq,
    output logic [hw_reset_pkg::IDX_W-1:0] storeAddr,
    input wire logic storeValid,
    input wire logic [7:0] storeData,
    output logic [7:0] idByte0,
    output logic [7:0] idByte1,
    output logic [7:0] idByte2,
    output logic [7:0] commonVoltageTrim,
    input wire logic linkCmdValid,
    output logic linkCmdAccept
);
    localparam logic [hw_reset_pkg::QCNT_W-1:0] QUAL_LAST = hw_reset_pkg::QCNT_W'(hw_reset_pkg::QUAL_CYCLES - 1);
    localparam logic [hw_reset_pkg::TCNT_W-1:0] LOAD_LAST =
        hw_reset_pkg::TCNT_W'(hw_reset_pkg::LOAD_LIMIT_CYCLES - 1);

    logic pinS1_q;
    logic pinS2_q;
    logic pinS3_q;
    logic filtLow_q;
    logic [hw_reset_pkg::QCNT_W-1:0] flipCnt_q;
    logic pinAgreeLow;
    logic pinAgreeHigh;
    logic pinDiffers;
    hw_reset_pkg::seq_state_e state_q;
    logic [hw_reset_pkg::TCNT_W-1:0] timeCnt_q;
    logic [hw_reset_pkg::IDX_W-1:0] loadIdx_q;
    logic [7:0] settings_q [hw_reset_pkg::SETTINGS_WORDS];
    logic blank_q;

    // Three-stage synchroniser; only the last two stages are compared.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pinS1_q <= 1'b1;
            pinS2_q <= 1'b1;
            pinS3_q <= 1'b1;
        end else begin
            pinS1_q <= hwResetN;
            pinS2_q <= pinS1_q;
            pinS3_q <= pinS2_q;
        end
    end

    assign pinAgreeLow = !pinS2_q && !pinS3_q;
    assign pinAgreeHigh = pinS2_q && pinS3_q;
    assign pinDiffers = filtLow_q ? pinAgreeHigh : pinAgreeLow;

    // One symmetric filter serves both edges, so a short high glitch inside a held reset is dropped too.
    // Cycles where the two stages disagree hold the count rather than clearing it.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            filtLow_q <= 1'b0;
            flipCnt_q <= '0;
        end else if (pinDiffers) begin
            if (flipCnt_q == QUAL_LAST) begin
                filtLow_q <= !filtLow_q;
                flipCnt_q <= '0;
            end else begin
                flipCnt_q <= flipCnt_q + 1'b1;
            end
        end else if (filtLow_q ? pinAgreeLow : pinAgreeHigh) begin
            flipCnt_q <= '0;
        end
    end

    // Sequence state; a new qualified reset during the load starts over.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= hw_reset_pkg::ST_READY;
        end else begin
            case (state_q)
                hw_reset_pkg::ST_READY: begin
                    if (filtLow_q) begin
                        state_q <= displayAwake ? hw_reset_pkg::ST_BLANK : hw_reset_pkg::ST_HOLD;
                    end
                end
                hw_reset_pkg::ST_BLANK: begin
                    if (timeCnt_q == BLANK_CYCLES - 1'b1) begin
                        state_q <= filtLow_q ? hw_reset_pkg::ST_HOLD : hw_reset_pkg::ST_LOAD;
                    end
                end
                hw_reset_pkg::ST_HOLD: begin
                    if (!filtLow_q) begin
                        state_q <= hw_reset_pkg::ST_LOAD;
                    end
                end
                // The watchdog ends a load that a silent store would otherwise never finish.
                hw_reset_pkg::ST_LOAD: begin
                    if (filtLow_q) begin
                        state_q <= hw_reset_pkg::ST_HOLD;
                    end else if ((storeValid && loadIdx_q == hw_reset_pkg::LAST_INDEX) || timeCnt_q == LOAD_LAST) begin
                        state_q <= hw_reset_pkg::ST_READY;
                    end
                end
                default: state_q <= hw_reset_pkg::ST_READY;
            endcase
        end
    end

    // Shared timer: blanking length, then the load watchdog that bounds the time to ready.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            timeCnt_q <= '0;
        end else if (state_q == hw_reset_pkg::ST_BLANK && timeCnt_q == BLANK_CYCLES - 1'b1) begin
            // Restart at the end of blanking so a release during blanking still gets the whole load watchdog.
            timeCnt_q <= '0;
        end else if (state_q == hw_reset_pkg::ST_BLANK || state_q == hw_reset_pkg::ST_LOAD) begin
            timeCnt_q <= timeCnt_q + 1'b1;
        end else begin
            timeCnt_q <= '0;
        end
    end

    // Settings return to defaults while in reset, then fill from the store word by word.
    // A silent store leaves the remaining words at default when the watchdog ends the load.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            loadIdx_q <= '0;
            for (int i = 0; i < hw_reset_pkg::SETTINGS_WORDS; i++) begin
                settings_q[i] <= hw_reset_pkg::SETTING_RESET;
            end
        end else if (state_q == hw_reset_pkg::ST_BLANK || state_q == hw_reset_pkg::ST_HOLD) begin
            loadIdx_q <= '0;
            for (int i = 0; i < hw_reset_pkg::SETTINGS_WORDS; i++) begin
                settings_q[i] <= hw_reset_pkg::SETTING_RESET;
            end
        end else if (state_q == hw_reset_pkg::ST_LOAD && storeValid && !filtLow_q) begin
            settings_q[loadIdx_q] <= storeData;
            loadIdx_q <= loadIdx_q + 1'b1;
        end
    end

    // The display stays blank from reset start until the sequence is ready.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            blank_q <= 1'b1;
        end else begin
            blank_q <= (state_q != hw_reset_pkg::ST_READY) || filtLow_q;
        end
    end

    assign blankDisplay = blank_q;
    assign coreResetN = !blank_q;
    // Ready leads the unblank by one cycle, since the blank flag is registered from the state.
    assign cmdReady = (state_q == hw_reset_pkg::ST_READY) && !filtLow_q;
    assign linkCmdAccept = linkCmdValid && cmdReady;
    assign storeReq = (state_q == hw_reset_pkg::ST_LOAD) && !filtLow_q;
    assign storeAddr = loadIdx_q;
    assign idByte0 = settings_q[hw_reset_pkg::ID0_INDEX];
    assign idByte1 = settings_q[hw_reset_pkg::ID1_INDEX];
    assign idByte2 = settings_q[hw_reset_pkg::ID2_INDEX];
    assign commonVoltageTrim = settings_q[hw_reset_pkg::TRIM_INDEX];

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    spike_reject_a: assert property ($rose(filtLow_q) |-> $past(flipCnt_q) == QUAL_LAST && $past(pinAgreeLow))
        else $error("Reset qualified without a full low run.");
    // A glitch inside a held reset only moves the run counter; the state must not leave the hold.
    glitch_hold_a: assert property ((state_q == hw_reset_pkg::ST_HOLD && filtLow_q && flipCnt_q != QUAL_LAST) |=>
        state_q == hw_reset_pkg::ST_HOLD)
        else $error("Hold left before the release qualified.");
    awake_blank_a: assert property ((state_q == hw_reset_pkg::ST_READY && filtLow_q && displayAwake) |=>
        state_q == hw_reset_pkg::ST_BLANK ##0 blankDisplay)
        else $error("Awake reset did not start blanking.");
    blank_bound_a: assert property (state_q == hw_reset_pkg::ST_BLANK |-> timeCnt_q < BLANK_CYCLES)
        else $error("Blanking ran past its length.");
    sleep_blank_a: assert property ((state_q == hw_reset_pkg::ST_READY && filtLow_q && !displayAwake) |=>
        state_q == hw_reset_pkg::ST_HOLD ##1 blankDisplay)
        else $error("Sleep reset did not hold the display blank.");
    load_start_a: assert property ((state_q == hw_reset_pkg::ST_HOLD && !filtLow_q) |=>
        storeReq && storeAddr == 3'h0)
        else $error("Settings load did not start on release.");
    load_store_a: assert property ((storeReq && storeValid) |=>
        settings_q[$past(loadIdx_q)] == $past(storeData))
        else $error("Stored setting not captured.");
    ready_bound_a: assert property (state_q == hw_reset_pkg::ST_LOAD |-> timeCnt_q <= LOAD_LAST)
        else $error("Load exceeded its watchdog.");
    watchdog_end_a: assert property ((state_q == hw_reset_pkg::ST_LOAD && timeCnt_q == LOAD_LAST) |=>
        state_q == hw_reset_pkg::ST_READY || state_q == hw_reset_pkg::ST_HOLD)
        else $error("Load ran past its watchdog.");
    cmd_gate_a: assert property (linkCmdAccept |->
        state_q == hw_reset_pkg::ST_READY ##1 !blankDisplay)
        else $error("Command accepted before ready.");
    release_unblank_a: assert property (state_q == hw_reset_pkg::ST_READY && !filtLow_q &&
        $past(state_q) == hw_reset_pkg::ST_LOAD |=> !blankDisplay && coreResetN)
        else $error("Display not released after the load.");
    defaults_a: assert property ($rose(blankDisplay) |=> idByte0 == 8'h00 && commonVoltageTrim == 8'h00)
        else $error("Settings not returned to defaults.");

    // Covers mark the reset paths that the bench is meant to reach.
    awake_reset_c: cover property (state_q == hw_reset_pkg::ST_BLANK ##1 state_q == hw_reset_pkg::ST_HOLD);
    sleep_reset_c: cover property (state_q == hw_reset_pkg::ST_HOLD ##1 state_q == hw_reset_pkg::ST_LOAD);
    full_load_c: cover property (storeValid && storeReq && storeAddr == 3'h7);
    spike_c: cover property (!filtLow_q && flipCnt_q != 10'h000 ##1 !filtLow_q && flipCnt_q == 10'h000);
    load_timeout_c: cover property (state_q == hw_reset_pkg::ST_LOAD && timeCnt_q == LOAD_LAST);
endmodule : display_hw_reset_sequencer

// *** tb/settings_store_model.sv ***
// Settings store model that answers each requested word on alternate cycles.
`timescale 1ns/1ps
module settings_store_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic storeReq,
    input wire logic [hw_reset_pkg::IDX_W-1:0] storeAddr,
    input wire logic [7:0] salt,
    input wire logic mute,
    output logic storeValid,
    output logic [7:0] storeData
);
    // Data between answers is inverted so that a stale word can never pass for a fresh one.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            storeValid <= 1'b0;
            storeData <= 8'hff;
        end else begin
            storeValid <= storeReq && !storeValid && !mute;
            storeData <= (storeReq && !storeValid) ? (salt ^ 8'(storeAddr)) : ~storeData;
        end
    end
endmodule : settings_store_model

// *** tb/tb_display_hw_reset_sequencer.sv ***
// Self-checking bench for the display hardware reset sequencer.
`timescale 1ns/1ps
module tb_display_hw_reset_sequencer;
    logic mclk, rst_n, hwResetN, displayAwake, linkCmdValid;
    logic blankDisplay, coreResetN, cmdReady, storeReq, storeValid, linkCmdAccept;
    logic [hw_reset_pkg::IDX_W-1:0] storeAddr;
    logic [7:0] storeData, idByte0, idByte1, idByte2, commonVoltageTrim, salt;
    logic mute;
    int n_errors = 0;
    int cmp_count = 0;
    // Host hold-offs after release, in clock cycles; a host keeping them always finds the device ready.
    localparam int HOST_CMD_WAIT = hw_reset_pkg::RELEASE_SLEEP_MS * hw_reset_pkg::CLK_MHZ * 1000;
    localparam int EXIT_SLEEP_WAIT = hw_reset_pkg::RELEASE_AWAKE_MS * hw_reset_pkg::CLK_MHZ * 1000;
    // A short blanking count of 20 cycles keeps the run small; the waits below are fixed cycle counts, not sized from it.
    display_hw_reset_sequencer #(.BLANK_CYCLES(hw_reset_pkg::TCNT_W'(20))) display_hw_reset_sequencer_i (
        .mclk(mclk), .rst_n(rst_n), .hwResetN(hwResetN), .displayAwake(displayAwake),
        .blankDisplay(blankDisplay), .coreResetN(coreResetN), .cmdReady(cmdReady), .storeReq(storeReq),
        .storeAddr(storeAddr), .storeValid(storeValid), .storeData(storeData), .idByte0(idByte0),
        .idByte1(idByte1), .idByte2(idByte2), .commonVoltageTrim(commonVoltageTrim),
        .linkCmdValid(linkCmdValid), .linkCmdAccept(linkCmdAccept));
    settings_store_model settings_store_model_i (.mclk(mclk), .rst_n(rst_n), .storeReq(storeReq),
        .storeAddr(storeAddr), .salt(salt), .mute(mute), .storeValid(storeValid), .storeData(storeData));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // Pin levels are held for whole clock periods, as a host timer would count them.
    task automatic pin(input logic v, input int n);
        hwResetN = v;
        repeat (n) @(negedge mclk);
    endtask : pin
    task automatic waitReady(input int bound, output int took);
        took = 0;
        while (took < bound && cmdReady !== 1'b1) begin
            @(negedge mclk);
            took++;
        end
        if (cmdReady !== 1'b1) begin
            n_errors++;
            $display("mismatch cmdReady expected 1 seen %b", cmdReady);
            final_report();
        end
    endtask : waitReady
    task automatic checkLoad(input logic [7:0] s);
        pin(1'b1, 2);
        check("idByte0", s, idByte0);
        check("idByte1", s ^ 8'h01, idByte1);
        check("idByte2", s ^ 8'h02, idByte2);
        check("commonVoltageTrim", s ^ 8'h03, commonVoltageTrim);
        check("blankDisplay", 8'h00, 8'(blankDisplay));
        check("coreResetN", 8'h01, 8'(coreResetN));
    endtask : checkLoad
    task automatic scIdle();
        linkCmdValid = 1'b1;
        pin(1'b1, 1);
        check("linkCmdAccept", 8'h01, 8'(linkCmdAccept));
        linkCmdValid = 1'b0;
    endtask : scIdle
    task automatic scSpike();
        pin(1'b0, 500);
        pin(1'b1, 1000);
        check("blankDisplay", 8'h00, 8'(blankDisplay));
        check("cmdReady", 8'h01, 8'(cmdReady));
    endtask : scSpike
    task automatic scSleep();
        int took;
        displayAwake = 1'b0;
        salt = 8'h3c;
        linkCmdValid = 1'b1;
        pin(1'b0, 1250);
        check("blankDisplay", 8'h01, 8'(blankDisplay));
        check("linkCmdAccept", 8'h00, 8'(linkCmdAccept));
        pin(1'b1, 500);
        check("storeReq", 8'h00, 8'(storeReq));
        check("blankDisplay", 8'h01, 8'(blankDisplay));
        pin(1'b0, 1250);
        pin(1'b1, 1);
        waitReady(1200, took);
        check("readyBeforeCmdWait", 8'h01, 8'(took < HOST_CMD_WAIT));
        check("linkCmdAccept", 8'h01, 8'(linkCmdAccept));
        linkCmdValid = 1'b0;
        checkLoad(8'h3c);
    endtask : scSleep
    task automatic scAwake();
        int took;
        displayAwake = 1'b1;
        salt = 8'h5a;
        pin(1'b0, 1250);
        check("blankDisplay", 8'h01, 8'(blankDisplay));
        check("idByte0", 8'h00, idByte0);
        check("commonVoltageTrim", 8'h00, commonVoltageTrim);
        pin(1'b1, 1);
        waitReady(1200, took);
        check("readyBeforeExitSleep", 8'h01, 8'(took < EXIT_SLEEP_WAIT));
        checkLoad(8'h5a);
    endtask : scAwake
    // A silent store exercises the load watchdog and a new reset landing in the middle of a load.
    task automatic scMute();
        int took;
        displayAwake = 1'b0;
        mute = 1'b1;
        pin(1'b0, 1250);
        pin(1'b1, 1000);
        check("storeReq", 8'h01, 8'(storeReq));
        check("cmdReady", 8'h00, 8'(cmdReady));
        pin(1'b0, 1250);
        check("storeReq", 8'h00, 8'(storeReq));
        check("blankDisplay", 8'h01, 8'(blankDisplay));
        pin(1'b1, 1);
        waitReady(5200, took);
        check("idByte0", 8'h00, idByte0);
        check("commonVoltageTrim", 8'h00, commonVoltageTrim);
        mute = 1'b0;
    endtask : scMute
    initial begin
        rst_n = 1'b0;
        hwResetN = 1'b1;
        displayAwake = 1'b0;
        linkCmdValid = 1'b0;
        salt = 8'h00;
        mute = 1'b0;
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        pin(1'b1, 2);
        scIdle();
        scSpike();
        scSleep();
        scAwake();
        scMute();
        final_report();
    end
endmodule : tb_display_hw_reset_sequencer
